/* File: inc/speu_pkg.sv */
// speu_pkg: register map, page types, result codes and states of the page writeback unit
// assumes a 32-bit Avalon-MM register bus and a same-clock page memory subsystem
package speu_pkg;
  // register byte offsets
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_DESC_PTR = 5'h04;
  localparam logic [4:0] REG_TARGET_PTR = 5'h08;
  localparam logic [4:0] REG_SLOT_PTR = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_RESULT = 5'h14;
  localparam logic [4:0] REG_FAULT_ADDR = 5'h18;
  localparam logic [4:0] REG_VERSION = 5'h1C;
  // leaf index and privilege
  localparam logic [7:0] LEAF_WRITEBACK = 8'h0B;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  // alignment low-bit widths: 32 B, 4 KB, 8 B, 128 B
  localparam int ALIGN_DESC = 5;
  localparam int ALIGN_PAGE = 12;
  localparam int ALIGN_SLOT = 3;
  localparam int ALIGN_META = 7;
  // page types
  localparam logic [2:0] TYPE_REGULAR = 3'h0;
  localparam logic [2:0] TYPE_THREAD_CONTROL = 3'h1;
  localparam logic [2:0] TYPE_TRIMMED = 3'h2;
  localparam logic [2:0] TYPE_SHADOW_STACK_FIRST = 3'h3;
  localparam logic [2:0] TYPE_SHADOW_STACK_REST = 3'h4;
  localparam logic [2:0] TYPE_CONTROL_PAGE = 3'h5;
  localparam logic [2:0] TYPE_VERSION_PAGE = 3'h6;
  // result codes
  localparam logic [31:0] RES_OK = 32'h0000_0000;
  localparam logic [31:0] ERR_NOT_BLOCKED = 32'h0000_0001;
  localparam logic [31:0] ERR_NOT_TRACKED = 32'h0000_0002;
  localparam logic [31:0] ERR_CHILD_PRESENT = 32'h0000_0003;
  localparam logic [31:0] ERR_SLOT_OCCUPIED = 32'h0000_0004;
  // hypervisor exit encoding
  localparam logic [7:0] CONFLICT_EXIT_REASON = 8'h01;
  localparam logic [7:0] PAGE_CONFLICT_QUALIFIER = 8'h01;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_GP = 2;
  localparam int ST_PF = 3;
  localparam int ST_VMEXIT = 4;
  localparam int ST_FLAGS = 8;
  // arithmetic flag positions within the six-bit flag field
  localparam int FL_SLOT = 0;
  localparam int FL_FAIL = 1;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHECK = 3'b001,
    S_TYPE = 3'b010,
    S_CRYPT = 3'b011,
    S_WRITE = 3'b100,
    S_COMMIT = 3'b101
  } speu_state_t;
endpackage

/* File: rtl/speu_writeback.sv */
// speu_writeback: sequencer for the privileged page writeback operation
// assumes operand facts, metadata and crypto engine sit on the same clock
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module speu_writeback (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] priv_level,
  input wire logic guest_mode,
  input wire logic virt_ext_en,
  input wire logic target_in_cache,
  input wire logic slot_in_cache,
  input wire logic [31:0] target_phys_addr,
  input wire logic [31:0] desc_linear_addr_field,
  input wire logic [31:0] desc_ctrl_page_field,
  input wire logic [31:0] desc_meta_ptr,
  input wire logic [31:0] desc_dest_ptr,
  input wire logic target_conflict,
  input wire logic slot_page_changing,
  input wire logic meta_valid,
  input wire logic [2:0] meta_page_type,
  input wire logic meta_blocked,
  input wire logic [2:0] meta_access_perm_bits,
  input wire logic meta_pending,
  input wire logic meta_modified,
  input wire logic meta_perm_restrict_bit,
  input wire logic [31:0] meta_enclave_addr,
  input wire logic slot_page_valid,
  input wire logic [2:0] slot_page_type,
  input wire logic block_ok,
  input wire logic track_ok,
  input wire logic tracking_busy,
  input wire logic ctl_conflict,
  input wire logic child_present,
  input wire logic virtual_child_count_nz,
  input wire logic [31:0] owner_enclave_identifier,
  input wire logic [31:0] own_enclave_identifier,
  input wire logic slot_value_nz,
  input wire logic crypt_done,
  output logic crypt_start,
  output logic [63:0] crypt_counter,
  output logic [31:0] crypt_src_ptr,
  output logic [31:0] crypt_dest_ptr,
  output logic [31:0] crypt_tag_ptr,
  output logic [31:0] hdr_enclave_identifier,
  output logic [31:0] hdr_enclave_addr,
  output logic [2:0] hdr_page_type,
  output logic [2:0] hdr_access_perm_bits,
  output logic hdr_pending,
  output logic hdr_modified,
  output logic hdr_perm_restrict_bit,
  output logic meta_buf_we,
  output logic [31:0] meta_buf_enclave_identifier,
  output logic desc_linear_addr_field_we,
  output logic slot_we,
  output logic [31:0] slot_version_value,
  output logic invalidate_we,
  output logic vm_exit,
  output logic [7:0] vm_exit_reason,
  output logic [7:0] vm_exit_qualifier,
  output logic [31:0] vm_exit_phys,
  output logic [31:0] vm_exit_linear
);
  speu_pkg::speu_state_t state_q;
  logic [31:0] desc_ptr_q, target_ptr_q, slot_ptr_q, result_q, fault_addr_q;
  logic [31:0] version_q, page_crypto_metadata_id_q;
  logic [5:0] flags_q;
  logic done_q, gp_q, pf_q, vmx_q, resp_q;
  logic start_req, leaf_ok, owned;
  logic chk_gp, chk_pf, chk_vmx;
  logic [31:0] chk_pf_addr;

  // one wait cycle per access; readdata is registered for the release edge
  assign avs_waitrequest = (avs_read | avs_write) & ~resp_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= (avs_read | avs_write) & ~resp_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !resp_q) begin
      case (avs_address)
        speu_pkg::REG_DESC_PTR: avs_readdata <= desc_ptr_q;
        speu_pkg::REG_TARGET_PTR: avs_readdata <= target_ptr_q;
        speu_pkg::REG_SLOT_PTR: avs_readdata <= slot_ptr_q;
        speu_pkg::REG_STATUS: begin
          avs_readdata <= {18'h00000, flags_q, 3'h0, vmx_q, pf_q, gp_q, done_q,
                           state_q != speu_pkg::S_IDLE};
        end
        speu_pkg::REG_RESULT: avs_readdata <= result_q;
        speu_pkg::REG_FAULT_ADDR: avs_readdata <= fault_addr_q;
        speu_pkg::REG_VERSION: avs_readdata <= version_q;
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // operands are frozen while an operation runs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      desc_ptr_q <= 32'h0000_0000;
      target_ptr_q <= 32'h0000_0000;
      slot_ptr_q <= 32'h0000_0000;
    end else if (avs_write && resp_q && state_q == speu_pkg::S_IDLE) begin
      if (avs_address == speu_pkg::REG_DESC_PTR) desc_ptr_q <= avs_writedata;
      if (avs_address == speu_pkg::REG_TARGET_PTR) target_ptr_q <= avs_writedata;
      if (avs_address == speu_pkg::REG_SLOT_PTR) slot_ptr_q <= avs_writedata;
    end
  end

  // writes commit only on the edge where waitrequest is low
  assign start_req = avs_write && resp_q && avs_address == speu_pkg::REG_CMD
                     && state_q == speu_pkg::S_IDLE;
  assign leaf_ok = avs_writedata[7:0] == speu_pkg::LEAF_WRITEBACK
                   && priv_level == speu_pkg::PRIV_KERNEL;
  assign owned = meta_page_type == speu_pkg::TYPE_REGULAR
                 || meta_page_type == speu_pkg::TYPE_THREAD_CONTROL
                 || meta_page_type == speu_pkg::TYPE_TRIMMED
                 || meta_page_type == speu_pkg::TYPE_SHADOW_STACK_FIRST
                 || meta_page_type == speu_pkg::TYPE_SHADOW_STACK_REST;

  // fault checks in the order the operation evaluates them; first hit wins
  always_comb begin
    chk_gp = 1'b0;
    chk_pf = 1'b0;
    chk_vmx = 1'b0;
    chk_pf_addr = 32'h0000_0000;
    if (desc_ptr_q[speu_pkg::ALIGN_DESC-1:0] != '0
        || target_ptr_q[speu_pkg::ALIGN_PAGE-1:0] != '0) begin
      chk_gp = 1'b1;
    end else if (!target_in_cache) begin
      chk_pf = 1'b1;
      chk_pf_addr = target_ptr_q;
    end else if (slot_ptr_q[speu_pkg::ALIGN_SLOT-1:0] != '0) begin
      chk_gp = 1'b1;
    end else if (!slot_in_cache) begin
      chk_pf = 1'b1;
      chk_pf_addr = slot_ptr_q;
    end else if (target_ptr_q[31:speu_pkg::ALIGN_PAGE]
                 == slot_ptr_q[31:speu_pkg::ALIGN_PAGE]) begin
      chk_gp = 1'b1;
    end else if (desc_linear_addr_field != '0 || desc_ctrl_page_field != '0) begin
      chk_gp = 1'b1;
    end else if (desc_meta_ptr[speu_pkg::ALIGN_META-1:0] != '0
                 || desc_dest_ptr[speu_pkg::ALIGN_PAGE-1:0] != '0) begin
      chk_gp = 1'b1;
    end else if (target_conflict) begin
      chk_vmx = guest_mode && virt_ext_en;
      chk_gp = !(guest_mode && virt_ext_en);
    end else if (slot_page_changing) begin
      chk_gp = 1'b1;
    end else if (!meta_valid) begin
      chk_pf = 1'b1;
      chk_pf_addr = target_ptr_q;
    end else if (!slot_page_valid || slot_page_type != speu_pkg::TYPE_VERSION_PAGE) begin
      chk_pf = 1'b1;
      chk_pf_addr = slot_ptr_q;
    end else if (owned && !block_ok) begin
      chk_gp = 1'b1;
    end else if (tracking_busy || ctl_conflict) begin
      chk_gp = 1'b1;
    end
  end

  // sequencer, result code, flags and exception status
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= speu_pkg::S_IDLE;
      result_q <= speu_pkg::RES_OK;
      flags_q <= 6'h00;
      done_q <= 1'b0;
      gp_q <= 1'b0;
      pf_q <= 1'b0;
      vmx_q <= 1'b0;
      fault_addr_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        speu_pkg::S_IDLE: begin
          if (start_req) begin
            done_q <= 1'b0;
            gp_q <= !leaf_ok;
            pf_q <= 1'b0;
            vmx_q <= 1'b0;
            if (leaf_ok) state_q <= speu_pkg::S_CHECK;
            else done_q <= 1'b1;
          end
        end
        speu_pkg::S_CHECK: begin
          if (chk_gp || chk_pf || chk_vmx) begin
            gp_q <= chk_gp;
            pf_q <= chk_pf;
            vmx_q <= chk_vmx;
            fault_addr_q <= chk_pf ? chk_pf_addr : fault_addr_q;
            done_q <= 1'b1;
            state_q <= speu_pkg::S_IDLE;
          end else begin
            flags_q <= 6'h00;
            result_q <= speu_pkg::RES_OK;
            state_q <= speu_pkg::S_TYPE;
          end
        end
        speu_pkg::S_TYPE: begin
          // error exits leave pages and slot alone
          if (owned && !meta_blocked) begin
            result_q <= speu_pkg::ERR_NOT_BLOCKED;
            flags_q[speu_pkg::FL_FAIL] <= 1'b1;
            done_q <= 1'b1;
            state_q <= speu_pkg::S_IDLE;
          end else if (owned && !track_ok) begin
            result_q <= speu_pkg::ERR_NOT_TRACKED;
            flags_q[speu_pkg::FL_FAIL] <= 1'b1;
            done_q <= 1'b1;
            state_q <= speu_pkg::S_IDLE;
          end else if (meta_page_type == speu_pkg::TYPE_CONTROL_PAGE
                       && (child_present || (guest_mode && virt_ext_en
                       && virtual_child_count_nz))) begin
            result_q <= speu_pkg::ERR_CHILD_PRESENT;
            flags_q[speu_pkg::FL_FAIL] <= 1'b1;
            done_q <= 1'b1;
            state_q <= speu_pkg::S_IDLE;
          end else begin
            state_q <= speu_pkg::S_CRYPT;
          end
        end
        speu_pkg::S_CRYPT: begin
          if (crypt_done) state_q <= speu_pkg::S_WRITE;
        end
        speu_pkg::S_WRITE: begin
          if (slot_value_nz) begin
            result_q <= speu_pkg::ERR_SLOT_OCCUPIED;
            flags_q[speu_pkg::FL_SLOT] <= 1'b1;
          end
          state_q <= speu_pkg::S_COMMIT;
        end
        speu_pkg::S_COMMIT: begin
          done_q <= 1'b1;
          state_q <= speu_pkg::S_IDLE;
        end
        default: state_q <= speu_pkg::S_IDLE;
      endcase
    end
  end

  // authentication header and metadata identifier
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hdr_enclave_identifier <= 32'h0000_0000;
      hdr_enclave_addr <= 32'h0000_0000;
      hdr_page_type <= 3'h0;
      hdr_access_perm_bits <= 3'h0;
      hdr_pending <= 1'b0;
      hdr_modified <= 1'b0;
      hdr_perm_restrict_bit <= 1'b0;
      page_crypto_metadata_id_q <= 32'h0000_0000;
    end else if (state_q == speu_pkg::S_CHECK) begin
      hdr_enclave_identifier <= 32'h0000_0000;
      hdr_enclave_addr <= 32'h0000_0000;
      hdr_page_type <= 3'h0;
      hdr_access_perm_bits <= 3'h0;
      hdr_pending <= 1'b0;
      hdr_modified <= 1'b0;
      hdr_perm_restrict_bit <= 1'b0;
      page_crypto_metadata_id_q <= 32'h0000_0000;
    end else if (state_q == speu_pkg::S_TYPE) begin
      if (owned) begin
        hdr_enclave_identifier <= owner_enclave_identifier;
        page_crypto_metadata_id_q <= owner_enclave_identifier;
      end else if (meta_page_type == speu_pkg::TYPE_CONTROL_PAGE) begin
        hdr_enclave_identifier <= 32'h0000_0000;
        page_crypto_metadata_id_q <= own_enclave_identifier;
      end else begin
        hdr_enclave_identifier <= 32'h0000_0000;
        page_crypto_metadata_id_q <= 32'h0000_0000;
      end
      hdr_enclave_addr <= meta_enclave_addr;
      hdr_page_type <= meta_page_type;
      hdr_access_perm_bits <= meta_access_perm_bits;
      hdr_pending <= meta_pending;
      hdr_modified <= meta_modified;
      hdr_perm_restrict_bit <= meta_perm_restrict_bit;
    end
  end

  // version source: increments by one at each commit and wraps at 32 bits, so a value repeats after 2^32 commits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      version_q <= 32'h0000_0001;
    end else if (state_q == speu_pkg::S_COMMIT) begin
      version_q <= version_q + 32'h0000_0001;
    end
  end

  // crypto request and memory write strobes, all registered one-cycle pulses
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crypt_start <= 1'b0;
      crypt_counter <= 64'h0;
      crypt_src_ptr <= 32'h0000_0000;
      crypt_dest_ptr <= 32'h0000_0000;
      crypt_tag_ptr <= 32'h0000_0000;
      meta_buf_we <= 1'b0;
      meta_buf_enclave_identifier <= 32'h0000_0000;
      desc_linear_addr_field_we <= 1'b0;
      slot_we <= 1'b0;
      slot_version_value <= 32'h0000_0000;
      invalidate_we <= 1'b0;
    end else begin
      crypt_start <= state_q == speu_pkg::S_TYPE && state_q != speu_pkg::S_CRYPT
                     && !((owned && (!meta_blocked || !track_ok))
                     || (meta_page_type == speu_pkg::TYPE_CONTROL_PAGE
                     && (child_present || (guest_mode && virt_ext_en
                     && virtual_child_count_nz))));
      if (state_q == speu_pkg::S_TYPE) begin
        crypt_counter <= {version_q, 32'h0000_0000};
        crypt_src_ptr <= target_ptr_q;
        crypt_dest_ptr <= desc_dest_ptr;
        crypt_tag_ptr <= desc_meta_ptr;
      end
      // metadata and descriptor write after the tag exists
      meta_buf_we <= state_q == speu_pkg::S_CRYPT && crypt_done;
      desc_linear_addr_field_we <= state_q == speu_pkg::S_CRYPT && crypt_done;
      if (state_q == speu_pkg::S_CRYPT && crypt_done) begin
        meta_buf_enclave_identifier <= page_crypto_metadata_id_q;
      end
      // slot first, invalidation one cycle later
      slot_we <= state_q == speu_pkg::S_WRITE;
      // held after the op, since the version counter moves on at commit
      if (state_q == speu_pkg::S_WRITE) begin
        slot_version_value <= version_q;
      end
      invalidate_we <= state_q == speu_pkg::S_COMMIT;
    end
  end

  // hypervisor exit record for a target conflict in guest mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vm_exit <= 1'b0;
      vm_exit_reason <= 8'h00;
      vm_exit_qualifier <= 8'h00;
      vm_exit_phys <= 32'h0000_0000;
      vm_exit_linear <= 32'h0000_0000;
    end else begin
      vm_exit <= state_q == speu_pkg::S_CHECK && chk_vmx;
      if (state_q == speu_pkg::S_CHECK && chk_vmx) begin
        vm_exit_reason <= speu_pkg::CONFLICT_EXIT_REASON;
        vm_exit_qualifier <= speu_pkg::PAGE_CONFLICT_QUALIFIER;
        vm_exit_phys <= target_phys_addr;
        vm_exit_linear <= target_ptr_q;
      end
    end
  end

  a_bad_align_gp: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == speu_pkg::S_CHECK && target_ptr_q[speu_pkg::ALIGN_PAGE-1:0] != '0
    |=> gp_q && done_q && state_q == speu_pkg::S_IDLE)
    else $error("misaligned target did not raise protection fault");
  a_same_page_gp: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == speu_pkg::S_CHECK && !chk_pf && !chk_vmx
    && target_ptr_q[31:speu_pkg::ALIGN_PAGE] == slot_ptr_q[31:speu_pkg::ALIGN_PAGE] |=> gp_q)
    else $error("shared page not faulted");
  a_conflict_exit: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == speu_pkg::S_CHECK && chk_vmx
    |=> vm_exit && !gp_q && vm_exit_linear == $past(target_ptr_q))
    else $error("conflict exit missing");
  a_not_blocked: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == speu_pkg::S_TYPE && owned && !meta_blocked
    |=> result_q == speu_pkg::ERR_NOT_BLOCKED && flags_q[speu_pkg::FL_FAIL]
    ##1 !slot_we && !invalidate_we)
    else $error("not-blocked exit wrong");
  a_error_no_write: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == speu_pkg::S_CHECK && (chk_gp || chk_pf || chk_vmx)
    |=> !crypt_start [*3])
    else $error("write activity after fault");
  a_counter_shift: assert property (@(posedge clock) disable iff (!rst_n)
    crypt_start |-> crypt_counter[31:0] == 32'h0000_0000 && crypt_counter[63:32] == version_q)
    else $error("counter not version shifted");
  a_slot_then_inval: assert property (@(posedge clock) disable iff (!rst_n)
    slot_we |=> invalidate_we)
    else $error("invalidate did not follow slot write");
  a_occupied_flag: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == speu_pkg::S_WRITE && slot_value_nz
    |=> flags_q[speu_pkg::FL_SLOT] && slot_we)
    else $error("occupied slot handling wrong");
  a_version_moves: assert property (@(posedge clock) disable iff (!rst_n)
    invalidate_we |-> version_q == $past(version_q) + 32'h0000_0001)
    else $error("version not advanced");
  a_leaf_refused: assert property (@(posedge clock) disable iff (!rst_n)
    start_req && !leaf_ok |=> gp_q && state_q == speu_pkg::S_IDLE)
    else $error("wrong leaf accepted");
endmodule
`default_nettype wire

/* File: testbench/speu_crypt_model.sv */
// speu_crypt_model: crypto engine model beside the writeback unit
// assumes crypt_start is a one-cycle pulse on the shared clock
`timescale 1ns/1ps
`default_nettype none
module speu_crypt_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic crypt_start,
  input wire logic [7:0] lat,
  output logic crypt_done
);
  logic [7:0] cnt_q;
  logic run_q;
  // single pulse, so a missing start cannot hide behind a stuck level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      crypt_done <= 1'b0;
    end else begin
      crypt_done <= run_q && (cnt_q == 8'h00);
      if (crypt_start) begin
        run_q <= 1'b1;
        cnt_q <= lat;
      end else if (run_q && cnt_q == 8'h00) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_secure_page_eviction_unit.sv */
// tb_secure_page_eviction_unit: register-level tests of the writeback sequencer
// assumes the crypto model and memory facts driven from bench variables
`timescale 1ns/1ps
`default_nettype none
module tb_secure_page_eviction_unit;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  logic [1:0] priv_level = 2'h0;
  logic guest_mode = 1'b0, virt_ext_en = 1'b0, crypt_done, crypt_start, invalidate_we, vm_exit;
  logic [7:0] gp = 8'h00, pf = 8'h00, lat = 8'h02, leaf = speu_pkg::LEAF_WRITEBACK;
  logic target_in_cache, slot_in_cache, meta_valid, slot_page_valid, block_ok;
  logic target_conflict, slot_page_changing, tracking_busy, ctl_conflict;
  logic [31:0] target_phys_addr = 32'h0001_2000, desc_linear_addr_field = 32'h0;
  logic [31:0] desc_ctrl_page_field = 32'h0, desc_meta_ptr = 32'h80, desc_dest_ptr = 32'h3000;
  logic [2:0] meta_page_type = 3'h0, meta_access_perm_bits = 3'h5, slot_page_type = 3'h6;
  logic meta_blocked = 1'b1, meta_pending = 1'b0, meta_modified = 1'b1;
  logic meta_perm_restrict_bit = 1'b1, track_ok = 1'b1, child_present = 1'b0;
  logic virtual_child_count_nz = 1'b0, slot_value_nz = 1'b0;
  logic [31:0] meta_enclave_addr = 32'h0040_5000, owner_enclave_identifier = 32'hA5A5_0001;
  logic [31:0] own_enclave_identifier = 32'h5A5A_0002, exp_ver = 32'h1, tgt = 32'h1000;
  logic [63:0] crypt_counter;
  logic [31:0] crypt_src_ptr, crypt_dest_ptr, crypt_tag_ptr, hdr_enclave_identifier;
  logic [31:0] hdr_enclave_addr, meta_buf_enclave_identifier, slot_version_value;
  logic [31:0] vm_exit_phys, vm_exit_linear;
  logic [2:0] hdr_page_type, hdr_access_perm_bits;
  logic hdr_pending, hdr_modified, hdr_perm_restrict_bit, meta_buf_we, desc_linear_addr_field_we, slot_we;
  logic [7:0] vm_exit_reason, vm_exit_qualifier;
  int errors = 0, n_tests = 0, n_wr = 0, cyc = 0;
  // one fault bit per scenario keeps the check order out of the picture
  assign {target_in_cache, slot_in_cache, meta_valid, slot_page_valid} = ~pf[3:0];
  assign {target_conflict, slot_page_changing, tracking_busy, ctl_conflict} = gp[3:0];
  assign block_ok = ~gp[4];
  speu_writeback speu_writeback_inst (.*);
  speu_crypt_model speu_crypt_model_inst (.clock(clock), .rst_n(rst_n),
    .crypt_start(crypt_start), .lat(lat), .crypt_done(crypt_done));
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    n_wr <= n_wr + int'(crypt_start === 1'b1) + int'(meta_buf_we === 1'b1)
      + int'(desc_linear_addr_field_we === 1'b1) + int'(slot_we === 1'b1) + int'(invalidate_we === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  // eres of all ones skips the result code, left open on faults
  task automatic op(input string nm, input logic [31:0] dsc, input logic [31:0] slot,
      input logic [31:0] est, input logic [31:0] eres, input int ewr);
    int w0;
    w0 = n_wr;
    bus(1'b1, speu_pkg::REG_DESC_PTR, dsc);
    bus(1'b1, speu_pkg::REG_TARGET_PTR, tgt);
    bus(1'b1, speu_pkg::REG_SLOT_PTR, slot);
    bus(1'b1, speu_pkg::REG_CMD, {24'h0, leaf});
    rdata = 32'h0;
    while (rdata[speu_pkg::ST_DONE] !== 1'b1) bus(1'b0, speu_pkg::REG_STATUS, 32'h0);
    chk({nm, " status"}, est, rdata);
    bus(1'b0, speu_pkg::REG_RESULT, 32'h0);
    if (eres !== 32'hFFFF_FFFF) chk({nm, " result"}, eres, rdata);
    chk({nm, " strobes"}, ewr, n_wr - w0);
    $display("test %s finished", nm);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    op("evict", 32'h20, 32'h2008, 32'h2, speu_pkg::RES_OK, 5);
    chk("counter", exp_ver, crypt_counter[63:32]);
    chk("crypt src", 32'h1000, crypt_src_ptr);
    chk("crypt dst", desc_dest_ptr, crypt_dest_ptr);
    chk("crypt tag", desc_meta_ptr, crypt_tag_ptr);
    chk("ctr low", 32'h0, crypt_counter[31:0]);
    chk("version", exp_ver, slot_version_value);
    bus(1'b0, speu_pkg::REG_VERSION, 32'h0);
    chk("next ver", exp_ver + 32'h1, rdata);
    chk("hdr id", owner_enclave_identifier, hdr_enclave_identifier);
    chk("meta id", owner_enclave_identifier, meta_buf_enclave_identifier);
    chk("hdr addr", meta_enclave_addr, hdr_enclave_addr);
    chk("hdr bits", {26'h0, 3'h5, 3'h0}, {26'h0, hdr_access_perm_bits, hdr_page_type});
    chk("hdr flags", 32'h6, {29'h0, hdr_perm_restrict_bit, hdr_modified, hdr_pending});
    lat <= 8'h28;
    slot_value_nz <= 1'b1;
    op("occupied", 32'h20, 32'h2008, 32'h102, speu_pkg::ERR_SLOT_OCCUPIED, 5);
    chk("version 2", exp_ver + 32'h1, slot_version_value);
    slot_value_nz <= 1'b0;
    meta_page_type <= speu_pkg::TYPE_VERSION_PAGE;
    op("va page", 32'h20, 32'h2008, 32'h2, speu_pkg::RES_OK, 5);
    chk("va ids", 32'h0, hdr_enclave_identifier | meta_buf_enclave_identifier);
    meta_page_type <= speu_pkg::TYPE_CONTROL_PAGE;
    child_present <= 1'b1;
    op("child", 32'h20, 32'h2008, 32'h202, speu_pkg::ERR_CHILD_PRESENT, 0);
    child_present <= 1'b0;
    {guest_mode, virt_ext_en, virtual_child_count_nz} <= 3'b111;
    op("vchild", 32'h20, 32'h2008, 32'h202, speu_pkg::ERR_CHILD_PRESENT, 0);
    virtual_child_count_nz <= 1'b0;
    op("ctl page", 32'h20, 32'h2008, 32'h2, speu_pkg::RES_OK, 5);
    chk("ctl ids", own_enclave_identifier, meta_buf_enclave_identifier | hdr_enclave_identifier);
    gp <= 8'h08;
    op("vmexit", 32'h20, 32'h2008, 32'h12, 32'hFFFF_FFFF, 0);
    chk("exit", {speu_pkg::CONFLICT_EXIT_REASON, 24'h001000}, {vm_exit_reason, vm_exit_linear[23:0]});
    chk("exit phys", target_phys_addr, vm_exit_phys);
    chk("exit qual", 32'(speu_pkg::PAGE_CONFLICT_QUALIFIER), 32'(vm_exit_qualifier));
    {guest_mode, virt_ext_en} <= 2'b00;
    meta_page_type <= speu_pkg::TYPE_REGULAR;
    for (int i = 0; i < 5; i++) begin
      gp <= 8'h01 << i;
      op("gp fault", 32'h20, 32'h2008, 32'h6, 32'hFFFF_FFFF, 0);
    end
    gp <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      pf <= 8'h01 << i;
      op("pf fault", 32'h20, 32'h2008, 32'hA, 32'hFFFF_FFFF, 0);
      bus(1'b0, speu_pkg::REG_FAULT_ADDR, 32'h0);
      chk("pf addr", i[0] ? 32'h1000 : 32'h2008, rdata);
    end
    pf <= 8'h00;
    slot_page_type <= speu_pkg::TYPE_REGULAR;
    op("slot type", 32'h20, 32'h2008, 32'hA, 32'hFFFF_FFFF, 0);
    slot_page_type <= speu_pkg::TYPE_VERSION_PAGE;
    op("desc align", 32'h30, 32'h2008, 32'h6, 32'hFFFF_FFFF, 0);
    tgt <= 32'h1800;
    op("tgt align", 32'h20, 32'h2008, 32'h6, 32'hFFFF_FFFF, 0);
    tgt <= 32'h1000;
    op("slot align", 32'h20, 32'h200C, 32'h6, 32'hFFFF_FFFF, 0);
    op("same page", 32'h20, 32'h1008, 32'h6, 32'hFFFF_FFFF, 0);
    desc_meta_ptr <= 32'h40;
    op("meta align", 32'h20, 32'h2008, 32'h6, 32'hFFFF_FFFF, 0);
    desc_meta_ptr <= 32'h80;
    desc_dest_ptr <= 32'h3800;
    op("dest align", 32'h20, 32'h2008, 32'h6, 32'hFFFF_FFFF, 0);
    desc_dest_ptr <= 32'h3000;
    desc_ctrl_page_field <= 32'h1000;
    op("ctl field", 32'h20, 32'h2008, 32'h6, 32'hFFFF_FFFF, 0);
    desc_ctrl_page_field <= 32'h0;
    desc_linear_addr_field <= 32'h4;
    op("linear_addr_field", 32'h20, 32'h2008, 32'h6, 32'hFFFF_FFFF, 0);
    desc_linear_addr_field <= 32'h0;
    meta_blocked <= 1'b0;
    op("unblocked", 32'h20, 32'h2008, 32'h202, speu_pkg::ERR_NOT_BLOCKED, 0);
    meta_blocked <= 1'b1;
    track_ok <= 1'b0;
    op("untracked", 32'h20, 32'h2008, 32'h202, speu_pkg::ERR_NOT_TRACKED, 0);
    track_ok <= 1'b1;
    leaf <= 8'h0C;
    // a refused start keeps the fail flag left by the untracked exit
    op("leaf", 32'h20, 32'h2008, 32'h206, 32'hFFFF_FFFF, 0);
    leaf <= speu_pkg::LEAF_WRITEBACK;
    priv_level <= 2'h3;
    op("priv", 32'h20, 32'h2008, 32'h206, 32'hFFFF_FFFF, 0);
    conclude();
  end
endmodule
`default_nettype wire
